// ---- rtl/stc_pkg.sv ----
package stc_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] STC_OFS_CTRL = 8'h00;
  localparam logic [7:0] STC_OFS_LOW = 8'h04;
  localparam logic [7:0] STC_OFS_HIGH = 8'h08;
  localparam logic [7:0] STC_OFS_STATUS = 8'h0c;
  localparam logic [7:0] STC_OFS_MASK = 8'h10;
  // Control register field positions
  localparam int STC_B_RUN = 0;
  localparam int STC_B_SRC = 1;
  localparam int STC_B_SYNCBYP = 2;
  localparam int STC_B_OSCEN = 3;
  localparam int STC_B_DIVLO = 4;
  localparam int STC_B_DIVHI = 5;
  localparam int STC_B_SYSCLK = 6;
  localparam int STC_B_WIDE = 7;
  // Writable control bits and reset values
  localparam logic [7:0] STC_CTRL_WMASK = 8'hbf;
  localparam logic [7:0] STC_CTRL_RST = 8'h00;
  localparam logic [15:0] STC_COUNT_RST = 16'h0000;
  localparam logic [15:0] STC_COUNT_MAX = 16'hffff;
  localparam logic [7:0] STC_BYTE_RST = 8'h00;
  // Status and mask layout
  localparam int STC_B_OVF = 0;
  localparam logic [7:0] STC_STAT_RST = 8'h00;
  localparam logic [7:0] STC_STAT_USED = 8'h01;
  // System clock cycles per instruction cycle
  localparam int STC_INSTR_DIV = 4;
  // Prescale code width and counter width
  localparam int STC_DIV_W = 2;
  localparam int STC_PSC_W = 3;
  // Prescale divider codes
  typedef enum logic [1:0] {
    STC_DIV1 = 2'b00,
    STC_DIV2 = 2'b01,
    STC_DIV4 = 2'b10,
    STC_DIV8 = 2'b11
  } stc_div_t;
endpackage

// ---- rtl/stc_edge.sv ----
`timescale 1ns/1ps
module stc_edge
  import stc_pkg::*;
#(
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Count input and mode
  input wire logic i_pin,
  input wire logic i_bypass,
  // Conditioned level and edges
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  // Elaboration check on the chain length
  if (STAGES < 2) begin : g_bad_stages
    $error("stc_edge needs at least two stages");
  end
  logic [STAGES-1:0] sync_reg;
  logic raw_reg;
  logic prev_reg;
  // Synchroniser chain and the direct sample
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_reg <= '0;
      raw_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], i_pin};
      raw_reg <= i_pin;
      prev_reg <= o_level;
    end
  end
  assign o_level = i_bypass ? raw_reg : sync_reg[STAGES-1];
  assign o_rise = o_level & ~prev_reg;
  assign o_fall = ~o_level & prev_reg;

  chk_sync_two_stage: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_bypass && o_rise |-> $past(i_pin, 2))
    else $error("synchronised rise not from the pin");
  chk_bypass_direct: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_bypass && o_rise |-> $past(i_pin))
    else $error("direct rise not from the pin");
endmodule

// ---- rtl/stc_presc.sv ----
`timescale 1ns/1ps
module stc_presc
  import stc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Input tick, ratio and clear
  input wire logic i_tick,
  input wire logic [STC_DIV_W-1:0] i_div,
  input wire logic i_clear,
  // Divided tick
  output logic o_tick
);
  logic [STC_PSC_W-1:0] cnt_reg;
  logic [STC_PSC_W-1:0] cnt_next;
  logic [STC_PSC_W-1:0] limit;
  assign limit = (i_div == STC_DIV1) ? 3'h0 :
                 (i_div == STC_DIV2) ? 3'h1 :
                 (i_div == STC_DIV4) ? 3'h3 : 3'h7;
  assign o_tick = i_tick & (cnt_reg >= limit) & ~i_clear;
  assign cnt_next = i_clear ? 3'h0 :
                    o_tick ? 3'h0 :
                    i_tick ? cnt_reg + 3'h1 : cnt_reg;
  // Hidden prescale counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  chk_presc_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    i_clear |=> cnt_reg == 3'h0) else $error("prescaler not cleared");
endmodule

// ---- rtl/stc_top.sv ----
`timescale 1ns/1ps
// How it works
// - The wide-access bit selects one 16-bit count access or two independent byte accesses.
// - In wide mode a low-byte read buffers the high byte and a low-byte write loads it from the buffer.
// - The divider field divides the count input by 1, 2, 4 or 8 for codes 00 to 11.
// - The prescale counter is hidden from software and cleared by any write to either count byte.
// - The oscillator enable bit runs the crystal oscillator or switches its inverter off.
// - With external source the input is synchronised when the bypass bit is 0 and sampled directly when 1.
// - With internal source the bypass bit is ignored and the instruction clock is counted.
// - Internal source advances the count once per instruction cycle, clock over four, after prescaling.
// - External source advances on each rising edge of the count input or oscillator pin, after prescaling.
// - The run bit enables counting and its clear freezes the count.
// - With the oscillator on, the two oscillator pins lose their port logic and read as zero.
// - In counter mode a falling edge must precede the first counted rise after reset, a write, or a stop with the input high.
// - Reads of the two count bytes return a coherent value while counting externally only in wide mode, through the buffer.
// - The system clock flag reads 1 while the system clock comes from this oscillator and is read only.
module stc_top
  import stc_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [31:0] O_PRDATA,
  // Count input pin and clock status
  input wire logic I_EXT_COUNT,
  input wire logic I_SYSCLK_FROM_XTAL,
  // Crystal oscillator pins
  input wire logic I_XTAL_IN,
  output logic O_XTAL_OUT,
  output logic O_XTAL_OE,
  output logic O_XTAL_EN,
  // Port logic on the two oscillator pins
  input wire logic [1:0] I_PORT_PIN,
  input wire logic [1:0] I_PORT_OUT,
  input wire logic [1:0] I_PORT_DIR_OUT,
  output logic [1:0] O_PORT_RD,
  output logic [1:0] O_PORT_OE,
  // Interrupt
  output logic O_IRQ
);
  // Control state
  logic [7:0] ctrl_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0] hibuf_reg;
  logic [7:0] hisnap_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] mask_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic armed_reg;
  logic armed_next;
  logic [1:0] phase_reg;

  // Control fields
  wire run = ctrl_reg[STC_B_RUN];
  wire src_ext = ctrl_reg[STC_B_SRC];
  wire sync_byp = ctrl_reg[STC_B_SYNCBYP];
  wire osc_en = ctrl_reg[STC_B_OSCEN];
  wire wide = ctrl_reg[STC_B_WIDE];
  wire [STC_DIV_W-1:0] div_sel = ctrl_reg[STC_B_DIVHI:STC_B_DIVLO];

  // Bus phases and address decode
  wire setup = I_PSEL & ~I_PENABLE;
  wire access = I_PSEL & I_PENABLE;
  wire wr_acc = access & I_PWRITE;
  wire rd_acc = access & ~I_PWRITE;
  wire hit_ctrl = I_PADDR == STC_OFS_CTRL;
  wire hit_low = I_PADDR == STC_OFS_LOW;
  wire hit_high = I_PADDR == STC_OFS_HIGH;
  wire hit_stat = I_PADDR == STC_OFS_STATUS;
  wire hit_mask = I_PADDR == STC_OFS_MASK;
  wire hit_any = hit_ctrl | hit_low | hit_high | hit_stat | hit_mask;
  wire [7:0] wbyte = I_PWDATA[7:0];
  wire wr_low = wr_acc & hit_low;
  wire wr_high = wr_acc & hit_high;
  wire rd_low = rd_acc & hit_low;
  wire rd_stat = rd_acc & hit_stat;
  wire cnt_wr = wr_low | wr_high;

  // Zero wait states
  assign O_PREADY = access;
  assign O_PRDATA = prdata_reg;
  assign O_PSLVERR = access & slverr_reg;

  // oscillator inverter runs only when enabled
  assign O_XTAL_EN = osc_en;
  assign O_XTAL_OE = osc_en;
  assign O_XTAL_OUT = osc_en & ~I_XTAL_IN;

  // port logic off while the oscillator runs
  assign O_PORT_RD = osc_en ? 2'b00 : I_PORT_PIN;
  assign O_PORT_OE = osc_en ? 2'b00 : I_PORT_DIR_OUT;

  // counted pin is the oscillator when enabled
  wire ext_src = osc_en ? I_XTAL_IN : I_EXT_COUNT;
  wire ext_level;
  wire ext_rise;
  wire ext_fall;

  // Input conditioning
  stc_edge #(
    .STAGES(2)
  ) u_edge (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_pin(ext_src),
    .i_bypass(sync_byp),
    .o_level(ext_level),
    .o_rise(ext_rise),
    .o_fall(ext_fall)
  );

  // Instruction cycle phase counter
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      phase_reg <= 2'b00;
    end else begin
      phase_reg <= phase_reg + 2'b01;
    end
  end
  wire instr_tick = phase_reg == 2'(STC_INSTR_DIV - 1);

  // arm on a falling edge, lose it on write or stop-high
  assign armed_next = cnt_wr ? 1'b0 :
                      (run & ext_fall) ? 1'b1 :
                      (~run & ext_level) ? 1'b0 : armed_reg;
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  // internal source ignores the bypass bit
  // external rises count only once armed
  wire raw_tick = src_ext ? (ext_rise & armed_reg) : instr_tick;
  wire psc_in = run & raw_tick;
  wire inc_tick;

  // Prescaler
  stc_presc u_presc (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_tick(psc_in),
    .i_div(div_sel),
    .i_clear(cnt_wr),
    .o_tick(inc_tick)
  );

  wire wrap = inc_tick & (count_reg == STC_COUNT_MAX) & ~cnt_wr;

  // a write takes priority over a coincident increment
  // wide low write loads both bytes, narrow writes one
  // high byte comes from the buffer in wide mode
  assign count_next = (wr_low & wide) ? {hibuf_reg, wbyte} :
                      wr_low ? {count_reg[15:8], wbyte} :
                      (wr_high & ~wide) ? {wbyte, count_reg[7:0]} :
                      inc_tick ? count_reg + 16'h0001 : count_reg;

  // Count register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      count_reg <= STC_COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // buffer loaded by wide low read or wide high write
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hibuf_reg <= STC_BYTE_RST;
    end else if (rd_low & wide) begin
      hibuf_reg <= hisnap_reg;
    end else if (wr_high & wide) begin
      hibuf_reg <= wbyte;
    end
  end

  // Control and mask writes
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctrl_reg <= STC_CTRL_RST;
      mask_reg <= STC_STAT_RST;
    end else if (wr_acc & hit_ctrl) begin
      ctrl_reg <= wbyte & STC_CTRL_WMASK;
    end else if (wr_acc & hit_mask) begin
      mask_reg <= wbyte & STC_STAT_USED;
    end
  end

  // overflow sets and wins over the read clear
  assign stat_next = (stat_reg & ~(rd_stat ? prdata_reg[7:0] : 8'h00))
                     | (wrap ? STC_STAT_USED : 8'h00);
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      stat_reg <= STC_STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end
  assign O_IRQ = |(stat_reg & mask_reg);

  // clock status bit is read only, taken live
  wire [7:0] ctrl_rd = {ctrl_reg[7], I_SYSCLK_FROM_XTAL, ctrl_reg[5:0]};
  // whole count is one register, but only wide mode keeps the two byte reads coherent
  // high address reads buffer in wide mode
  wire [7:0] high_rd = wide ? hibuf_reg : count_reg[15:8];
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                       hit_low ? count_reg[7:0] :
                       hit_high ? high_rd :
                       hit_stat ? stat_reg :
                       hit_mask ? mask_reg : 8'h00;

  // Read data and high snapshot captured in setup
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      prdata_reg <= 32'h0000_0000;
      hisnap_reg <= STC_BYTE_RST;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= I_PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      hisnap_reg <= count_reg[15:8];
      slverr_reg <= ~hit_any;
    end
  end

  // Assertions
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);

  sequence s_wide_low_read;
    rd_low && wide;
  endsequence
  sequence s_wide_low_write;
    wr_low && wide;
  endsequence
  sequence s_timer_tick;
    run && !src_ext && instr_tick && !cnt_wr && div_sel == STC_DIV1;
  endsequence

  chk_wrap_sets_flag: assert property (
    wrap |=> stat_reg[STC_B_OVF] && count_reg == STC_COUNT_RST)
    else $error("wrap did not set overflow");
  chk_run_freeze: assert property (
    !run && !cnt_wr |=> $stable(count_reg))
    else $error("count moved while stopped");
  chk_wide_read_buf: assert property (
    s_wide_low_read |=> hibuf_reg == $past(hisnap_reg))
    else $error("high buffer not loaded on low read");
  chk_wide_write_hi: assert property (
    s_wide_low_write |=> count_reg[15:8] == $past(hibuf_reg))
    else $error("high byte not loaded from buffer");
  chk_narrow_high_wr: assert property (
    wr_high && !wide |=> count_reg[15:8] == $past(wbyte))
    else $error("narrow high write lost");
  chk_pins_read_zero: assert property (
    osc_en |-> O_PORT_RD == 2'b00 && O_PORT_OE == 2'b00)
    else $error("oscillator pins not isolated");
  chk_osc_off: assert property (
    !osc_en |-> !O_XTAL_OE && !O_XTAL_OUT)
    else $error("oscillator driven while off");
  chk_write_disarms: assert property (
    cnt_wr |=> !armed_reg)
    else $error("write did not disarm counter");
  chk_unarmed_hold: assert property (
    src_ext && !armed_reg && !cnt_wr |=> $stable(count_reg))
    else $error("counted before falling edge");
  // one step in four cycles, all five cycles seen running
  chk_timer_rate: assert property (
    (run && !src_ext && div_sel == STC_DIV1 && !access)[*5]
    |-> count_reg != $past(count_reg, 4))
    else $error("timer missed an instruction cycle");
  chk_clk_flag: assert property (
    setup && hit_ctrl && !I_PWRITE
    |=> prdata_reg[STC_B_SYSCLK] == $past(I_SYSCLK_FROM_XTAL))
    else $error("clock status bit wrong");
  chk_narrow_low_wr: assert property (
    wr_low && !wide |=> count_reg == {$past(count_reg[15:8]), $past(wbyte)})
    else $error("narrow low write lost");
  chk_wide_high_buf: assert property (
    wr_high && wide |=> $stable(count_reg) && hibuf_reg == $past(wbyte))
    else $error("wide high write reached the count");
  chk_wide_high_rd: assert property (
    setup && hit_high && !I_PWRITE && wide |=> prdata_reg[7:0] == $past(hibuf_reg))
    else $error("wide high read not from buffer");
  chk_timer_step: assert property (
    s_timer_tick |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("timer tick not counted");
  chk_timer_gaps: assert property (
    !src_ext && !instr_tick && !cnt_wr |=> $stable(count_reg))
    else $error("timer moved between instruction cycles");
  chk_ext_rise_only: assert property (
    src_ext && !ext_rise && !cnt_wr |=> $stable(count_reg))
    else $error("counter moved without a rise");
  chk_stop_high_disarm: assert property (
    !run && ext_level && !cnt_wr |=> !armed_reg)
    else $error("stop with input high kept the arm");
  chk_clk_flag_ro: assert property (
    wr_acc && hit_ctrl |=> !ctrl_reg[STC_B_SYSCLK])
    else $error("clock status bit written");
  chk_stat_sticky: assert property (
    stat_reg[STC_B_OVF] && !rd_stat |=> stat_reg[STC_B_OVF])
    else $error("overflow flag lost");
  chk_stat_read_clr: assert property (
    rd_stat && prdata_reg[STC_B_OVF] && !wrap |=> !stat_reg[STC_B_OVF])
    else $error("overflow flag not cleared by read");
endmodule

// ---- tb/stc_ext_src.sv ----
`timescale 1ns/1ps
module stc_ext_src (
  // Clock
  input wire logic i_clk,
  // Count input toward the block
  output logic o_pin
);
  initial o_pin = 1'b0;

  // Park the input at a level
  task automatic level(input logic l);
    @(posedge i_clk);
    o_pin <= l;
  endtask

  // fall then rise
  // Each pulse is a low half then a high half, so every rise follows a fall unless the pin starts low
  task automatic pulses(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      o_pin <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// ---- tb/sixteen_bit_timer_counter_tb.sv ----
`timescale 1ns/1ps
module sixteen_bit_timer_counter_tb;
  import stc_pkg::*;
  typedef struct {logic [31:0] d; int t; logic e;} stc_note_t;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sysflag = 0, xin = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [1:0] pin = 0, pout = 0, pdir = 0;
  wire logic pready, pslverr, xout, xoe, xen, irq, ext;
  wire logic [31:0] prdata;
  wire logic [1:0] prd, poe;
  int mismatches = 0, comparisons = 0, cycles = 0;
  stc_note_t q[$];
  stc_note_t nt;

  // Clock
  always #50 clk = ~clk;

  stc_top i_dut (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .O_PRDATA(prdata), .I_EXT_COUNT(ext), .I_SYSCLK_FROM_XTAL(sysflag), .I_XTAL_IN(xin),
    .O_XTAL_OUT(xout), .O_XTAL_OE(xoe), .O_XTAL_EN(xen), .I_PORT_PIN(pin),
    .I_PORT_OUT(pout), .I_PORT_DIR_OUT(pdir), .O_PORT_RD(prd), .O_PORT_OE(poe), .O_IRQ(irq));
  stc_ext_src i_src (.i_clk(clk), .o_pin(ext));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  // Note the expected word (within d..d+t) and error flag, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input int t = 0,
                    input logic e = 0);
    q.push_back('{d, t, e});
    apb(0, a, 0);
  endtask

  // Watch completed reads, compare with the oldest note; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (psel && pen && pready === 1'b1 && !pwr) begin
      nt = q.pop_front();
      comparisons++;
      if (^prdata === 1'bx || prdata < nt.d || prdata > nt.d + nt.t || pslverr !== nt.e) begin
        mismatches++;
        $display("mismatch at %0t: read %h at %h", $time, prdata, paddr);
      end
    end
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] hv, lv, hn;
    logic [7:0] ofs[5];
    ofs = '{STC_OFS_CTRL, STC_OFS_LOW, STC_OFS_HIGH, STC_OFS_STATUS, STC_OFS_MASK};
    hv = 8'($urandom(44486));
    repeat (20) @(posedge clk);
    rst <= 0;
    // Reset values and an unmapped place
    for (int i = 0; i < 5; i++) rd(ofs[i], 32'h0);
    rd(8'h14, 32'h0, 0, 1'b1);
    // Oscillator on: pins lose port logic, inverter runs
    wr(STC_OFS_CTRL, 32'hff);
    @(posedge clk);
    xin <= 1'($urandom);
    pin <= 2'($urandom);
    pdir <= 2'($urandom);
    @(posedge clk);
    #1;
    chk(prd === 2'b00 && poe === 2'b00, "pins not released");
    chk(xen === 1'b1 && xoe === 1'b1 && xout === ~xin, "oscillator off");
    rd(STC_OFS_CTRL, 32'hbf);
    sysflag <= 1;
    rd(STC_OFS_CTRL, 32'hff);
    sysflag <= 0;
    wr(STC_OFS_CTRL, 32'h0);
    #1;
    chk(prd === pin && poe === pdir && xen === 1'b0, "port logic lost");
    // Timer mode, each divider code, about sixteen ticks expected
    for (int d = 0; d < 4; d++) begin
      wr(STC_OFS_CTRL, 32'h0);
      wr(STC_OFS_LOW, 32'h0);
      wr(STC_OFS_HIGH, 32'h0);
      wr(STC_OFS_CTRL, 32'(d << 4) | 32'h1);
      repeat (64 << d) @(posedge clk);
      wr(STC_OFS_CTRL, 32'h0);
      rd(STC_OFS_LOW, 32'd15, 2);
    end
    // Counter mode, sync and direct, with and without a leading fall
    for (int b = 0; b < 2; b++) begin
      for (int h = 0; h < 2; h++) begin
        wr(STC_OFS_CTRL, 32'(b << 2) | 32'h2);
        i_src.level(h[0]);
        wr(STC_OFS_LOW, 32'h0);
        wr(STC_OFS_HIGH, 32'h0);
        wr(STC_OFS_CTRL, 32'(b << 2) | 32'h3);
        i_src.pulses(5);
        repeat (6) @(posedge clk);
        wr(STC_OFS_CTRL, 32'(b << 2) | 32'h2);
        rd(STC_OFS_LOW, h ? 32'd5 : 32'd4);
        i_src.pulses(3);
        rd(STC_OFS_LOW, h ? 32'd5 : 32'd4);
      end
    end
    // Wide access through the high byte buffer
    lv = 8'($urandom);
    hn = ~hv;
    wr(STC_OFS_CTRL, 32'h80);
    wr(STC_OFS_HIGH, 32'(hv));
    wr(STC_OFS_LOW, 32'(lv));
    rd(STC_OFS_LOW, 32'(lv));
    rd(STC_OFS_HIGH, 32'(hv));
    wr(STC_OFS_HIGH, 32'(hn));
    rd(STC_OFS_HIGH, 32'(hn));
    rd(STC_OFS_LOW, 32'(lv));
    rd(STC_OFS_HIGH, 32'(hv));
    wr(STC_OFS_CTRL, 32'h0);
    rd(STC_OFS_HIGH, 32'(hv));
    // Wrap, sticky status, mask and interrupt
    wr(STC_OFS_MASK, 32'h0);
    wr(STC_OFS_LOW, 32'hff);
    wr(STC_OFS_HIGH, 32'hff);
    wr(STC_OFS_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    wr(STC_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk(irq === 1'b0, "masked irq high");
    wr(STC_OFS_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(irq === 1'b1, "irq low");
    rd(STC_OFS_MASK, 32'h1);
    rd(STC_OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk(irq === 1'b0, "irq not cleared");
    rd(STC_OFS_STATUS, 32'h0);
    rd(STC_OFS_HIGH, 32'h0, 1);
    give_verdict();
  end
endmodule
